// *** core/ptl_pkg.sv ***
// ptl_pkg: constants and types shared by the packet test loopback engine
// assumes: one 10 MHz clock, registers reached over AXI4-Lite
package ptl_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] PTL_REG_CTRL   = 8'h00;  // mode, enables, delay, offset
   localparam logic [7:0] PTL_REG_CMD    = 8'h04;  // command strobes
   localparam logic [7:0] PTL_REG_STATUS = 8'h08;  // engine state
   localparam logic [7:0] PTL_REG_DLMAP  = 8'h0C;  // active downlink slots
   localparam logic [7:0] PTL_REG_SEED   = 8'h10;  // generator seed

   // ctrl field positions
   localparam int PTL_CTRL_LOOP_BIT  = 0;   // 1 loopback, 0 pseudorandom
   localparam int PTL_CTRL_COPY_BIT  = 1;   // copy first slot to later slots
   localparam int PTL_CTRL_MULTI_BIT = 2;   // multi-slot extension enable
   localparam int PTL_CTRL_DLY_LSB   = 4;   // loop delay in radio blocks
   localparam int PTL_CTRL_OFS_LSB   = 8;   // downlink slot offset

   // cmd strobe bits
   localparam int PTL_CMD_START_BIT = 0;
   localparam int PTL_CMD_STOP_BIT  = 1;

   // reset values
   localparam logic [31:0] PTL_CTRL_RESET = 32'h0000_0010;  // delay 1 block
   localparam logic [14:0] PTL_SEED_RESET = 15'h7FFF;

   // loop delay limits in radio blocks
   localparam int PTL_DLY_MIN = 1;
   localparam int PTL_DLY_MAX = 5;   // fewer than six

   // generator: 15-bit maximal length, period 32767
   localparam int PTL_PRBS_W = 15;

   // axi response codes
   localparam logic [1:0] PTL_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PTL_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PTL_IDLE,
      PTL_ACTIVE
   } ptl_state_t;

endpackage

// *** core/ptl_engine.sv ***
// ptl_engine: packet test-mode payload engine of the mobile terminal
// assumes: radio block strobes and slot numbers arrive synchronous to clock;
// headers and layer 1 processing are added downstream of the payload
//
// Summary of operation
// - test command with tbf and pdu count starts; here the start bit of the cmd register starts it, no pdu count
// - payload is pseudorandom or looped downlink
// - loopback copies downlink payload, else undefined
// - later uplink slots may copy first slot
// - uplink blocks keep headers and normal coding
// - loop delay one to five radio blocks
// - uplink sent when uplink state flag grants
// - control blocks still received and answered
// - uplink control blocks only when polled
// - repeat previous payload on control block
// - uplink tbf end leaves test mode
// - abnormal tbf end leaves test mode
// - generator period at least 32767 bits
// - nth downlink slot maps to nth uplink
// - unmapped uplink slots copy last mapped
// - single downlink slot uses basic rules
// - downlink count from offset, wraps 7 to 0
// - uplink slots counted from slot zero
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module ptl_engine
   import ptl_pkg::*;
#(
   parameter int PW = 32,   // payload word width
   parameter int DD = 8     // delay line depth in blocks
)(
   input  wire logic          clock,
   input  wire logic          nrst,
   // axi4-lite slave
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // downlink side, one strobe per received radio block
   input  wire logic          dl_blk,
   input  wire logic          dl_ctrl,
   input  wire logic [2:0]    dl_slot,
   input  wire logic [PW-1:0] dl_payload,
   input  wire logic          dl_tbf,
   input  wire logic          poll,
   // uplink side, one strobe per uplink opportunity
   input  wire logic          ul_blk,
   input  wire logic [2:0]    ul_slot,
   input  wire logic          usf_grant,
   input  wire logic          tbf_end,
   input  wire logic          tbf_abort,
   output logic               ul_valid,
   output logic               ul_ctrl_ok,
   output logic [PW-1:0]      ul_payload,
   output logic               test_active
);

   // ------------------------------------------------------------
   // registers and bus slave
   // ------------------------------------------------------------
   logic [31:0] ctrl;
   logic [7:0]  dl_map;
   logic [14:0] seed;
   logic [7:0]  awa;
   logic        aw_held, w_held;
   logic [31:0] wd;
   logic [3:0]  ws;

   wire do_wr     = aw_held && w_held && !s_axi_bvalid;
   wire wr_ctrl   = do_wr && awa == PTL_REG_CTRL;
   wire wr_cmd    = do_wr && awa == PTL_REG_CMD;
   wire wr_map    = do_wr && awa == PTL_REG_DLMAP;
   wire wr_seed   = do_wr && awa == PTL_REG_SEED;
   wire wr_ok     = wr_ctrl || wr_cmd || wr_map || wr_seed;
   wire start_cmd = wr_cmd && ws[0] && wd[PTL_CMD_START_BIT];
   wire stop_cmd  = wr_cmd && ws[0] && wd[PTL_CMD_STOP_BIT];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // address and data capture, either order
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         awa     <= 8'h00;
         wd      <= 32'h0000_0000;
         ws      <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            awa     <= s_axi_awaddr;
         end else if (do_wr) aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wd     <= s_axi_wdata;
            ws     <= s_axi_wstrb;
         end else if (do_wr) w_held <= 1'b0;
      end
   end

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // write response and register update
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= PTL_RESP_OKAY;
         ctrl         <= PTL_CTRL_RESET;
         dl_map       <= 8'h01;
         seed         <= PTL_SEED_RESET;
      end else begin
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? PTL_RESP_OKAY : PTL_RESP_SLVERR;
         end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
         if (wr_ctrl) ctrl <= merge(ctrl, wd, ws);
         if (wr_map && ws[0]) dl_map <= wd[7:0];
         if (wr_seed && wd[14:0] != 15'h0000) seed <= wd[14:0];   // zero would lock the generator
      end
   end

   // read data select; unmapped offsets read zero with slverr
   wire        rd_ok   = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= PTL_REG_SEED;
   wire [31:0] rd_word = (s_axi_araddr == PTL_REG_CTRL)   ? ctrl :
                         (s_axi_araddr == PTL_REG_STATUS) ? {31'h0000_0000, test_active} :
                         (s_axi_araddr == PTL_REG_DLMAP)  ? {24'h00_0000, dl_map} :
                         (s_axi_araddr == PTL_REG_SEED)   ? {17'h0_0000, seed} : 32'h0000_0000;
   // read response, one cycle after the address is taken
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= PTL_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? PTL_RESP_OKAY : PTL_RESP_SLVERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
   end

   // ------------------------------------------------------------
   // control decode
   // ------------------------------------------------------------
   wire       loop_mode = ctrl[PTL_CTRL_LOOP_BIT];
   wire       copy_en   = ctrl[PTL_CTRL_COPY_BIT];
   wire       multi_en  = ctrl[PTL_CTRL_MULTI_BIT];
   wire [2:0] dly_raw   = ctrl[PTL_CTRL_DLY_LSB +: 3];
   wire [2:0] dl_ofs    = ctrl[PTL_CTRL_OFS_LSB +: 3];
   // clamp to the allowed one to five blocks
   wire [2:0] loop_round_trip_delay = (dly_raw < 3'(PTL_DLY_MIN)) ? 3'(PTL_DLY_MIN) :
                                      (dly_raw > 3'(PTL_DLY_MAX)) ? 3'(PTL_DLY_MAX) : dly_raw;

   // ------------------------------------------------------------
   // test-mode state
   // ------------------------------------------------------------
   ptl_state_t state, next_state;
   wire tbf_gone = tbf_end || tbf_abort || stop_cmd;

   always_comb begin
      next_state = state;
      unique case (state)
         PTL_IDLE:   if (start_cmd && !tbf_gone) next_state = PTL_ACTIVE;
         PTL_ACTIVE: if (tbf_gone) next_state = PTL_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // slot numbering: downlink relative to offset, uplink from zero
   // ------------------------------------------------------------
   wire [2:0] dl_rel = dl_slot - dl_ofs;   // wraps through slot 7 to 0
   // count active slots between offset and this slot
   function automatic logic [2:0] rank(input logic [7:0] map, input logic [2:0] ofs,
                                       input logic [2:0] rel);
      logic [2:0] n;
      n = 3'd0;
      for (int k = 0; k < 8; k++) begin
         if (3'(k) < rel && map[3'(ofs + 3'(k))]) n = n + 3'd1;
      end
      return n;
   endfunction
   wire [2:0] dl_idx  = rank(dl_map, dl_ofs, dl_rel);
   wire [3:0] dl_cnt  = 4'($countones(dl_map));
   wire       multi   = multi_en && dl_cnt > 4'd1;
   wire [2:0] last_dl = 3'(dl_cnt - 4'd1);
   wire [2:0] ul_idx  = ul_slot;
   wire [2:0] ul_map  = (ul_idx > last_dl) ? last_dl : ul_idx;

   // ------------------------------------------------------------
   // pseudorandom generator x^15 + x^14 + 1, period 32767
   // ------------------------------------------------------------
   logic [14:0]   lfsr;
   logic [14:0]   lfsr_adv;
   logic [PW-1:0] prbs_word;
   always_comb begin
      logic [14:0] s;
      s = lfsr;
      prbs_word = '0;
      for (int b = 0; b < PW; b++) begin
         prbs_word[b] = s[14];
         s = {s[13:0], s[14] ^ s[13]};
      end
      lfsr_adv = s;   // state after one word
   end

   // ------------------------------------------------------------
   // per-slot delay lines of received payload
   // ------------------------------------------------------------
   logic [PW-1:0] dline [8][DD];
   logic [PW-1:0] last_word;
   wire take_dl = state == PTL_ACTIVE && dl_blk && !dl_ctrl && dl_tbf && dl_map[dl_slot];
   wire [2:0] wslot = multi ? dl_idx : 3'd0;

   // shift the mapped slot line on each tbf data block received on an active slot in test mode
   always_ff @(posedge clock) begin
      if (take_dl) begin
         dline[wslot][0] <= dl_payload;
         for (int d = 1; d < DD; d++) dline[wslot][d] <= dline[wslot][d-1];
      end
   end

   wire [2:0]    rslot    = multi ? ul_map : 3'd0;
   wire          use_copy = copy_en && !multi && ul_idx != 3'd0;
   wire [PW-1:0] looped   = dline[rslot][loop_round_trip_delay - 3'd1];
   wire [PW-1:0] fresh    = loop_mode ? looped : prbs_word;
   wire          send     = state == PTL_ACTIVE && ul_blk && usf_grant;
   wire [PW-1:0] next_payload = use_copy ? last_word : fresh;

   // ------------------------------------------------------------
   // uplink output and state registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state       <= PTL_IDLE;
         lfsr        <= PTL_SEED_RESET;
         ul_valid    <= 1'b0;
         ul_ctrl_ok  <= 1'b0;
         ul_payload  <= '0;
         last_word   <= '0;
         test_active <= 1'b0;
      end else begin
         state       <= next_state;
         test_active <= next_state == PTL_ACTIVE;
         ul_valid    <= send && !tbf_gone;
         ul_ctrl_ok  <= poll && ul_blk;
         if (start_cmd && state == PTL_IDLE) lfsr <= seed;
         else if (send && !loop_mode && !use_copy && !(dl_blk && dl_ctrl))
            lfsr <= lfsr_adv;                                             // repeat on control block
         if (send) begin
            ul_payload <= next_payload;
            if (ul_idx == 3'd0) last_word <= fresh;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_leave_on_end;
      @(posedge clock) disable iff (!nrst)
      (tbf_end || tbf_abort) |=> !test_active && state == PTL_IDLE;
   endproperty
   a_leave_on_end: assert property (p_leave_on_end) else $error("test mode kept after tbf end");

   property p_leave_on_abort;
      @(posedge clock) disable iff (!nrst)
      tbf_abort ##1 !start_cmd |=> !test_active;
   endproperty
   a_leave_on_abort: assert property (p_leave_on_abort) else $error("test mode kept after abort");

   property p_start;
      @(posedge clock) disable iff (!nrst)
      (state == PTL_IDLE && start_cmd && !tbf_gone) |=> test_active;
   endproperty
   a_start: assert property (p_start) else $error("start command not accepted");

   property p_delay_range;
      @(posedge clock) disable iff (!nrst)
      loop_round_trip_delay >= 3'd1 && loop_round_trip_delay <= 3'd5;
   endproperty
   a_delay_range: assert property (p_delay_range) else $error("loop delay out of range");

   property p_grant_only;
      @(posedge clock) disable iff (!nrst)
      ul_valid |-> $past(ul_blk) && $past(usf_grant) && $past(state) == PTL_ACTIVE;
   endproperty
   a_grant_only: assert property (p_grant_only) else $error("uplink sent without grant");

   property p_poll_only;
      @(posedge clock) disable iff (!nrst)
      ul_ctrl_ok |-> $past(poll);
   endproperty
   a_poll_only: assert property (p_poll_only) else $error("control block without poll");

   property p_prbs_payload;
      @(posedge clock) disable iff (!nrst)
      (send && !loop_mode && !use_copy) |=> ul_payload == $past(prbs_word);
   endproperty
   a_prbs_payload: assert property (p_prbs_payload) else $error("payload not pseudorandom");

   property p_ul_map;
      @(posedge clock) disable iff (!nrst)
      multi |-> ul_map <= last_dl;
   endproperty
   a_ul_map: assert property (p_ul_map) else $error("uplink slot maps past last downlink");

   property p_flag_follows;
      @(posedge clock) disable iff (!nrst)
      ##1 test_active == (state == PTL_ACTIVE);
   endproperty
   a_flag_follows: assert property (p_flag_follows) else $error("active flag disagrees with state");

endmodule

// *** verification/ptl_sim.sv ***
// ptl_sim: base station simulator side of the radio link
// assumes: the bench calls its tasks; one clock
`timescale 1ns/1ns
module ptl_sim (
   input  wire logic   clock,
   output logic        dl_blk,
   output logic        dl_ctrl,
   output logic [2:0]  dl_slot,
   output logic [31:0] dl_payload,
   output logic        dl_tbf,
   output logic        poll,
   output logic        ul_blk,
   output logic [2:0]  ul_slot,
   output logic        usf_grant,
   output logic        tbf_end,
   output logic        tbf_abort
);
   logic [31:0] lfsr = 32'h3330_83E4;

   // -----------------------------------------
   // maximal 32-bit generator, long period
   // -----------------------------------------
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // idle levels, downlink tbf present
   initial begin
      {dl_blk, dl_ctrl, poll, ul_blk, usf_grant, tbf_end, tbf_abort} = 7'h00;
      {dl_slot, ul_slot} = 6'h00;
      dl_payload = 32'h0000_0000;
      dl_tbf = 1'b1;
   end

   // one downlink block, random payload, same coding as uplink
   task automatic dl(input logic [2:0] s, input logic c, output logic [31:0] w);
      @(posedge clock);
      lfsr = step(lfsr);
      w = lfsr;
      dl_blk <= 1'b1;
      dl_ctrl <= c;
      dl_slot <= s;
      dl_payload <= w;
      @(posedge clock);
      dl_blk <= 1'b0;
      dl_ctrl <= 1'b0;
      dl_payload <= ~w; // inverted word, differs from the block
   endtask

   // one uplink opportunity, usf grant and poll
   task automatic ul(input logic [2:0] s, input logic g, input logic p);
      @(posedge clock);
      ul_blk <= 1'b1;
      ul_slot <= s;
      usf_grant <= g;
      poll <= p;
      @(posedge clock);
      ul_blk <= 1'b0;
      usf_grant <= 1'b0;
      poll <= 1'b0;
   endtask

   // uplink tbf release or abnormal end
   task automatic term(input logic ab);
      @(posedge clock);
      if (ab) tbf_abort <= 1'b1;
      else tbf_end <= 1'b1;
      @(posedge clock);
      tbf_abort <= 1'b0;
      tbf_end <= 1'b0;
   endtask
endmodule

// *** verification/tb.sv ***
// tb: self-checking bench of the packet test loopback engine
// assumes: ptl_sim drives the radio side; bench is axi master
`timescale 1ns/1ns
module tb import ptl_pkg::*;;
   localparam logic [1:0] OK = PTL_RESP_OKAY;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, ul_payload, dl_payload, w, x;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, ul_valid, ul_ctrl_ok, test_active;
   logic        dl_blk, dl_ctrl, dl_tbf, poll, ul_blk, usf_grant, tbf_end, tbf_abort;
   logic [2:0]  dl_slot, ul_slot;
   logic [1:0]  bresp, rresp;
   logic [14:0] g, s;
   logic [32:0] uq[$], e;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   logic [31:0] h[$];
   int          fails = 0, check_count = 0, d, n;

   // -----------------------------------------
   // clock, design and simulator
   // -----------------------------------------
   always #50 clock = ~clock;

   ptl_engine dut (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dl_blk(dl_blk),
      .dl_ctrl(dl_ctrl), .dl_slot(dl_slot), .dl_payload(dl_payload), .dl_tbf(dl_tbf), .poll(poll),
      .ul_blk(ul_blk), .ul_slot(ul_slot), .usf_grant(usf_grant), .tbf_end(tbf_end),
      .tbf_abort(tbf_abort), .ul_valid(ul_valid), .ul_ctrl_ok(ul_ctrl_ok),
      .ul_payload(ul_payload), .test_active(test_active));

   ptl_sim sim (.clock(clock), .dl_blk(dl_blk), .dl_ctrl(dl_ctrl), .dl_slot(dl_slot),
      .dl_payload(dl_payload), .dl_tbf(dl_tbf), .poll(poll), .ul_blk(ul_blk), .ul_slot(ul_slot),
      .usf_grant(usf_grant), .tbf_end(tbf_end), .tbf_abort(tbf_abort));

   // -----------------------------------------
   // compare, verdict, bus tasks
   // -----------------------------------------
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // generator model x^15 + x^14 + 1: next state and one word
   function automatic logic [46:0] gen(input logic [14:0] st);
      logic [31:0] v;
      v = 32'h0;
      for (int b = 0; b < 32; b++) begin
         v[b] = st[14];
         st = {st[13:0], st[14] ^ st[13]};
      end
      return {st, v};
   endfunction

   task automatic conclude;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // bounded wait ran out
   task automatic tmo;
      if (n >= 40) begin
         fails++;
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      n = 0;
      bq.push_back(r);
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
      end while (!bvalid && n < 40);
      bready <= 1'b0;
      tmo();
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] x);
      n = 0;
      rq.push_back(x);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (arready && arvalid) arvalid <= 1'b0;
      end while (!rvalid && n < 40);
      rready <= 1'b0;
      tmo();
   endtask

   // monitor: oldest note against each result
   always @(posedge clock) begin
      if (ul_valid) begin
         if (uq.size() == 0) chk(34'h0, 34'h1);
         else begin
            e = uq.pop_front();
            if (e[32]) chk(34'(ul_payload), 34'(e[31:0]));
            else if (e[0]) chk(34'(ul_payload), 34'(x));
            else begin
               {s, x} = gen(g);
               if (!e[1]) g = s;
               chk(34'(ul_payload), 34'(x));
            end
         end
      end
      if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
      if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
   end

   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      rd(PTL_REG_CTRL, {OK, PTL_CTRL_RESET});
      rd(PTL_REG_CMD, 34'h0);
      rd(PTL_REG_DLMAP, 34'h1);
      rd(PTL_REG_SEED, {OK, 17'h0, PTL_SEED_RESET});
      rd(8'h14, {PTL_RESP_SLVERR, 32'h0});
      wr(8'h14, 32'h0, PTL_RESP_SLVERR);
      // every delay code, ends clamped; single dl slot
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 1 : ((i > 5) ? 5 : i);
         wr(PTL_REG_CTRL, 32'h5 | 32'(i << 4), OK);
         rd(PTL_REG_STATUS, 34'h0);
         wr(PTL_REG_CMD, 32'h1, OK);
         rd(PTL_REG_STATUS, 34'h1);
         h = {};
         for (int k = 0; k < 6; k++) begin
            sim.dl(3'h0, 1'b0, w);
            h.push_back(w);
            if (k == 3) sim.dl(3'h0, 1'b1, w);
         end
         uq.push_back({1'b1, h[6 - d]});
         sim.ul(3'(i), 1'b1, i[0]);
         #1 chk(34'(ul_ctrl_ok), 34'(i[0]));
         sim.ul(3'h0, 1'b0, 1'b0);
         if (i % 3 == 2) wr(PTL_REG_CMD, 32'h2, OK);
         else sim.term(i % 3 == 1);
         rd(PTL_REG_STATUS, 34'h0);
         sim.ul(3'h0, 1'b1, 1'b0);
      end
      // pseudorandom fill from a new seed, slot 1 copies, control block freezes
      g = 15'h1234;
      wr(PTL_REG_CTRL, 32'h12, OK);
      wr(PTL_REG_SEED, 32'h1234, OK);
      wr(PTL_REG_CMD, 32'h1, OK);
      for (int k = 0; k < 4; k++) begin
         uq.push_back({31'h0, k == 2, k == 1});
         fork
            if (k == 2) sim.dl(3'h0, 1'b1, w);
            sim.ul(3'(k == 1), 1'b1, 1'b0);
         join
      end
      sim.term(1'b0);
      // offset 6 skips idle slot 6, wraps 7 to 0
      wr(PTL_REG_DLMAP, 32'h81, OK);
      wr(PTL_REG_CTRL, 32'h615, OK);
      wr(PTL_REG_CMD, 32'h1, OK);
      h = {};
      sim.dl(3'h7, 1'b0, w);
      h.push_back(w);
      sim.dl(3'h0, 1'b0, w);
      h.push_back(w);
      for (int k = 0; k < 3; k++) begin
         uq.push_back({1'b1, h[(k > 0) ? 1 : 0]});
         sim.ul(3'(k), 1'b1, 1'b0);
      end
      sim.term(1'b1);
      repeat (4) @(posedge clock);
      chk(34'(uq.size()), 34'h0);
      conclude();
   end
endmodule
